// [dv/rshc_far_side.sv]
`timescale 1ns/1ps
// ==========================================================
// Reference inputs and VCXO loop model
// ==========================================================
module rshc_far_side (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [1:0]  up_i,
  input  wire logic [14:0] phase_i,
  input  wire logic        synth_ok_i,
  output logic      [1:0]  clk_active_o,
  output logic             vcxo_tick_o,
  output logic      [14:0] phase_diff_o,
  output logic             synth_locked_o
);
  logic [1:0] div_q;

  // Divided VCXO pulse, one in four cycles
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q          <= 2'h0;
      vcxo_tick_o    <= 1'b0;
      clk_active_o   <= 2'h3;
      phase_diff_o   <= 15'h0000;
      synth_locked_o <= 1'b1;
    end else begin
      div_q          <= div_q + 2'h1;
      vcxo_tick_o    <= (div_q == 2'h3);
      clk_active_o   <= up_i;
      phase_diff_o   <= phase_i;
      synth_locked_o <= synth_ok_i;
    end
  end
endmodule

// [dv/tb_rshc_top.sv]
`timescale 1ns/1ps
module tb_rshc_top;
  // ==========================================================
  // Clock, reset, bus
  // ==========================================================
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [1:0]  up = 2'h3;
  logic [14:0] phase = 15'h0000;
  logic        synth_ok = 1'b1;
  logic        pin_sel = 1'b0;
  logic [1:0]  act;
  logic        tick, s_lock, ref_sel, ho, force_o, lock, irq_n;
  logic [14:0] pd;
  logic [31:0] rv;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;

  always #2.5 clk = ~clk;

  rshc_top #(.PRE_W(20)) DUT (
    .ref_clk_i(clk), .resetn_i(rstn), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .clk_active_i(act),
    .pin_ref_select_i(pin_sel), .vcxo_tick_i(tick),
    .phase_diff_i(pd), .synth_locked_i(s_lock), .ref_sel_o(ref_sel),
    .holdover_o(ho), .vcxo_force_o(force_o), .lock_o(lock),
    .irq_out_n_o(irq_n));

  rshc_far_side far (
    .ref_clk_i(clk), .resetn_i(rstn), .up_i(up), .phase_i(phase),
    .synth_ok_i(synth_ok), .clk_active_o(act), .vcxo_tick_o(tick),
    .phase_diff_o(pd), .synth_locked_o(s_lock));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("[ERR] %0t got %h want %h", $time, g, e);
      n_errors++;
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wait_ho(input logic v, input int n);
    for (int i = 0; i < n && ho !== v; i++) @(posedge clk);
    chk(ho, v);
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    logic [4:0]  a[6] = '{5'h00, 5'h04, 5'h08, 5'h14, 5'h18, 5'h1C};
    logic [31:0] e[6] = '{32'h40, 32'hF10, 32'h100, 32'h0, 32'h0,
                          32'h0};
    chk(ref_sel, 1'b0);
    chk(ho, 1'b0);
    chk(force_o, 1'b1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk(rv, e[i]);
    end
    $display("test reset done");
  endtask

  task automatic t_lock();
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h14, 32'h4);
    bus(1'b1, 5'h10, 32'h7F);
    repeat (4) @(posedge clk);
    chk(force_o, 1'b0);
    chk(lock, 1'b1);
    chk(irq_n, 1'b1);
    phase <= 15'h0101;
    repeat (5) @(posedge clk);
    chk(lock, 1'b0);
    chk(irq_n, 1'b0);
    bus(1'b0, 5'h0C, 32'h0);
    chk(rv[2], 1'b0);
    bus(1'b1, 5'h10, 32'h4);
    bus(1'b0, 5'h10, 32'h0);
    chk(rv[2], 1'b0);
    phase <= 15'h0100;
    repeat (3) @(posedge clk);
    bus(1'b1, 5'h10, 32'h0);
    chk(lock, 1'b0);
    bus(1'b1, 5'h10, 32'h4);
    repeat (3) @(posedge clk);
    chk(lock, 1'b1);
    chk(irq_n, 1'b1);
    bus(1'b1, 5'h14, 32'h0);
    synth_ok <= 1'b0;
    repeat (5) @(posedge clk);
    chk(lock, 1'b0);
    chk(irq_n, 1'b1);
    synth_ok <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b1, 5'h10, 32'h8);
    $display("test lock done");
  endtask

  task automatic t_auto();
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b1, 5'h10, 32'h7F);
    up <= 2'h2;
    wait_ho(1'b1, 4);
    bus(1'b0, 5'h0C, 32'h0);
    chk(rv[6:4], 3'h0);
    chk(ref_sel, 1'b0);
    wait_ho(1'b0, 60);
    chk(ref_sel, 1'b1);
    bus(1'b1, 5'h10, 32'h7F);
    up <= 2'h0;
    wait_ho(1'b1, 4);
    repeat (40) @(posedge clk);
    chk(ho, 1'b1);
    bus(1'b1, 5'h10, 32'h40);
    bus(1'b0, 5'h10, 32'h0);
    chk(rv[6], 1'b0);
    up <= 2'h3;
    wait_ho(1'b0, 60);
    chk(ref_sel, 1'b1);
    repeat (10) @(posedge clk);
    chk(ref_sel, 1'b1);
    bus(1'b1, 5'h00, 32'h27);
    repeat (4) @(posedge clk);
    chk(ref_sel, 1'b0);
    $display("test auto done");
  endtask

  task automatic t_manual();
    bus(1'b1, 5'h00, 32'h0);
    repeat (4) @(posedge clk);
    bus(1'b1, 5'h00, 32'h18);
    wait_ho(1'b1, 4);
    bus(1'b0, 5'h0C, 32'h0);
    chk(rv[5:4], 2'h2);
    chk(ref_sel, 1'b0);
    wait_ho(1'b0, 60);
    chk(ref_sel, 1'b1);
    $display("test manual done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_lock();
    t_auto();
    t_manual();
    summarize();
  end
endmodule

// [rtl/rshc_holdoff.sv]
`timescale 1ns/1ps
module rshc_holdoff #(
  parameter int PW = 20,
  parameter int CW = 8
) (
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          run_i,
  input  wire logic          tick_i,
  input  wire logic [PW-1:0] prescale_i,
  input  wire logic [CW-1:0] start_i,
  output logic               expire_o
);

  logic [PW-1:0] pre_q;
  logic [CW-1:0] cnt_q;
  logic          step;

  assign step     = run_i && tick_i && (pre_q == prescale_i);
  assign expire_o = step && (cnt_q <= CW'(1));

  // ==========================================================
  // Prescaler, idle unless run
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_q <= '0;
    end else if (!run_i || step) begin
      pre_q <= '0;
    end else if (tick_i) begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // ==========================================================
  // Down-counter, expires on the step from one or zero and reloads start_i
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (!run_i || expire_o) begin
      cnt_q <= start_i;
    end else if (step) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

endmodule

// [rtl/rshc_pkg.sv]
package rshc_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam int          AW          = 5;
  localparam logic [4:0]  OFS_CTRL    = 5'h00;
  localparam logic [4:0]  OFS_HOLDOFF = 5'h04;
  localparam logic [4:0]  OFS_PHASE_WINDOW_THRESHOLD = 5'h08;
  localparam logic [4:0]  OFS_STATUS  = 5'h0C;
  localparam logic [4:0]  OFS_LATCHED = 5'h10;
  localparam logic [4:0]  OFS_IE      = 5'h14;

  // ==========================================================
  // Control fields
  // ==========================================================
  localparam int          HO_EN_BIT   = 0;
  localparam int          MODE_LO     = 1;
  localparam int          MODE_HI     = 2;
  localparam int          SRC_BIT     = 3;
  localparam int          REGSEL_BIT  = 4;
  localparam int          REVERT_BIT  = 5;
  localparam int          FORCE_BIT   = 6;
  localparam int          PRIO_BIT    = 7;
  localparam int          CTRL_W      = 8;
  localparam logic [1:0]  MODE_AUTO_HOLD = 2'h3;
  localparam logic [7:0]  CTRL_RST    = 8'h40;

  // ==========================================================
  // Hold-off fields
  // ==========================================================
  localparam int          START_LO    = 0;
  localparam int          START_W     = 8;
  localparam int          PRE_LO      = 8;
  localparam int          PRE_W       = 20;
  localparam logic [7:0]  START_RST   = 8'h10;
  localparam logic [19:0] PRE_RST     = 20'h0000F;

  // ==========================================================
  // Lock threshold and status
  // ==========================================================
  localparam int          TH_W        = 15;
  localparam logic [14:0] TH_RST      = 15'h0100;
  localparam int          ST_W        = 7;
  localparam int          ST_VCXO     = 2;
  localparam int          ST_SYNTH    = 3;
  localparam logic [6:0]  IE_RST      = 7'h00;
  localparam logic [6:0]  LAT_MASK    = 7'h5F;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int          CLK_MHZ     = 200;

  typedef enum logic {
    RSHC_NORMAL,
    RSHC_HOLD
  } rshc_state_t;

  // Status word, bit 6 down to bit 0
  typedef struct packed {
    logic       ref_valid_now;
    logic       selected_input_status;
    logic       holdover_now_n;
    logic       synth_pll_locked_now_n;
    logic       vcxo_pll_locked_now_n;
    logic [1:0] input_active_now;
  } rshc_stat_t;

endpackage

// [rtl/rshc_sticky.sv]
`timescale 1ns/1ps
module rshc_sticky #(
  parameter int W = 7
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] fault_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] lat_o
);

  // ==========================================================
  // Latched fault bits, set wins over clear
  // ==========================================================
  for (genvar k = 0; k < W; k++) begin : g_bit
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        lat_o[k] <= 1'b0;
      end else if (fault_i[k]) begin
        lat_o[k] <= 1'b1;
      end else if (clr_i[k]) begin
        lat_o[k] <= 1'b0;
      end
    end
  end

endmodule

// [rtl/rshc_top.sv]
`timescale 1ns/1ps
module rshc_top #(
  parameter int PRE_W = rshc_pkg::PRE_W
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [1:0]  clk_active_i,
  input  wire logic        pin_ref_select_i,
  input  wire logic        vcxo_tick_i,
  input  wire logic [14:0] phase_diff_i,
  input  wire logic        synth_locked_i,
  output logic             ref_sel_o,
  output logic             holdover_o,
  output logic             vcxo_force_o,
  output logic             lock_o,
  output logic             irq_out_n_o
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [rshc_pkg::CTRL_W-1:0]  ctrl_q;
  logic [rshc_pkg::START_W-1:0] start_q;
  logic [PRE_W-1:0]             pre_q;
  logic [rshc_pkg::TH_W-1:0]    th_q;
  logic [rshc_pkg::ST_W-1:0]    ie_q;
  logic [rshc_pkg::ST_W-1:0]    lat_q;
  logic [rshc_pkg::ST_W-1:0]    fault;
  logic [rshc_pkg::ST_W-1:0]    clr;
  logic [31:0]                  rdata_q;
  logic                         wait_q;
  logic                         wr_fire;
  rshc_pkg::rshc_stat_t         stat_q;
  rshc_pkg::rshc_state_t        st_q;
  rshc_pkg::rshc_state_t        st_d;
  logic                         sel_q;
  logic                         sel_d;
  logic                         route_q;
  logic                         route_d;
  logic                         auto_mode;
  logic                         manual_hold;
  logic                         req_sel;
  logic                         prio;
  logic                         revert;
  logic                         los_evt;
  logic                         expire;
  logic                         hold_run;
  logic                         vcxo_lol;
  logic                         irq_src;
  logic                         ref_valid_d;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Avalon slave handshake, one wait state
  // ==========================================================
  assign wr_fire = avs_write_i && !wait_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      case (avs_address_i)
        rshc_pkg::OFS_CTRL:    rdata_q <= 32'(ctrl_q);
        rshc_pkg::OFS_HOLDOFF: rdata_q <= 32'({pre_q, start_q});
        rshc_pkg::OFS_PHASE_WINDOW_THRESHOLD: rdata_q <= 32'(th_q);
        rshc_pkg::OFS_STATUS:  rdata_q <= 32'(stat_q);
        rshc_pkg::OFS_LATCHED:
          rdata_q <= 32'(~lat_q & rshc_pkg::LAT_MASK);
        rshc_pkg::OFS_IE:      rdata_q <= 32'(ie_q);
        default:               rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ==========================================================
  // Configuration registers
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= rshc_pkg::CTRL_RST;
    end else if (wr_fire && avs_address_i == rshc_pkg::OFS_CTRL) begin
      ctrl_q <= 8'(be_merge(32'(ctrl_q), avs_writedata_i,
                            avs_byteenable_i));
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_q <= rshc_pkg::START_RST;
      pre_q   <= PRE_W'(rshc_pkg::PRE_RST);
    end else if (wr_fire && avs_address_i == rshc_pkg::OFS_HOLDOFF) begin
      {pre_q, start_q} <= (PRE_W+8)'(be_merge(32'({pre_q, start_q}),
        avs_writedata_i, avs_byteenable_i));
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      th_q <= rshc_pkg::TH_RST;
    end else if (wr_fire && avs_address_i == rshc_pkg::OFS_PHASE_WINDOW_THRESHOLD) begin
      th_q <= 15'(be_merge(32'(th_q), avs_writedata_i,
                           avs_byteenable_i));
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ie_q <= rshc_pkg::IE_RST;
    end else if (wr_fire && avs_address_i == rshc_pkg::OFS_IE) begin
      ie_q <= 7'(be_merge(32'(ie_q), avs_writedata_i,
                          avs_byteenable_i));
    end
  end

  // ==========================================================
  // Mode decode
  // ==========================================================
  assign auto_mode   = ctrl_q[rshc_pkg::HO_EN_BIT] &&
    ctrl_q[rshc_pkg::MODE_HI:rshc_pkg::MODE_LO] ==
    rshc_pkg::MODE_AUTO_HOLD;
  assign manual_hold = !ctrl_q[rshc_pkg::HO_EN_BIT];
  assign req_sel     = ctrl_q[rshc_pkg::SRC_BIT] ?
    ctrl_q[rshc_pkg::REGSEL_BIT] : pin_ref_select_i;
  assign prio        = ctrl_q[rshc_pkg::PRIO_BIT];
  assign revert      = ctrl_q[rshc_pkg::REVERT_BIT];
  assign los_evt     = !clk_active_i[route_q] && !lat_q[route_q];
  assign hold_run    = (st_q == rshc_pkg::RSHC_HOLD);

  rshc_holdoff #(
    .PW (PRE_W),
    .CW (rshc_pkg::START_W)
  ) u_holdoff (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .run_i      (hold_run),
    .tick_i     (vcxo_tick_i),
    .prescale_i (pre_q),
    .start_i    (start_q),
    .expire_o   (expire)
  );

  // ==========================================================
  // Selection state machine
  // ==========================================================
  always_comb begin
    st_d    = st_q;
    sel_d   = sel_q;
    route_d = route_q;
    case (st_q)
      rshc_pkg::RSHC_NORMAL: begin
        if (manual_hold) begin
          if (req_sel != sel_q) begin
            sel_d = req_sel;
            st_d  = rshc_pkg::RSHC_HOLD;
          end
        end else if (auto_mode) begin
          if (los_evt) begin
            st_d = rshc_pkg::RSHC_HOLD;
          end else if (revert && route_q != prio &&
                       clk_active_i[prio]) begin
            route_d = prio;
            sel_d   = prio;
          end
        end else begin
          sel_d   = req_sel;
          route_d = req_sel;
        end
      end
      rshc_pkg::RSHC_HOLD: begin
        if (manual_hold) begin
          sel_d = req_sel;
          if (expire) begin
            route_d = req_sel;
            st_d    = rshc_pkg::RSHC_NORMAL;
          end
        end else if (auto_mode) begin
          if (expire) begin
            if (clk_active_i[route_q]) begin
              st_d = rshc_pkg::RSHC_NORMAL;
            end else if (clk_active_i[!route_q]) begin
              route_d = !route_q;
              sel_d   = !route_q;
              st_d    = rshc_pkg::RSHC_NORMAL;
            end
          end
        end else begin
          st_d = rshc_pkg::RSHC_NORMAL;
        end
      end
      default: st_d = rshc_pkg::RSHC_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q    <= rshc_pkg::RSHC_NORMAL;
      sel_q   <= 1'b0;
      route_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      sel_q   <= sel_d;
      route_q <= route_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_sel_o  <= 1'b0;
      holdover_o <= 1'b0;
    end else begin
      ref_sel_o  <= route_d;
      holdover_o <= (st_d == rshc_pkg::RSHC_HOLD);
    end
  end

  // ==========================================================
  // Momentary status
  // ==========================================================
  assign vcxo_lol = !ctrl_q[rshc_pkg::FORCE_BIT] &&
                    (phase_diff_i > th_q);
  assign ref_valid_d = auto_mode ? (st_d != rshc_pkg::RSHC_HOLD) :
                       clk_active_i[sel_d];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= '{ref_valid_now: 1'b0, selected_input_status: 1'b0,
                  holdover_now_n: 1'b1, synth_pll_locked_now_n: 1'b0,
                  vcxo_pll_locked_now_n: 1'b0, input_active_now: 2'h0};
    end else begin
      stat_q.input_active_now       <= clk_active_i;
      stat_q.vcxo_pll_locked_now_n  <= !vcxo_lol;
      stat_q.synth_pll_locked_now_n <= synth_locked_i;
      stat_q.holdover_now_n         <= (st_d != rshc_pkg::RSHC_HOLD);
      stat_q.selected_input_status  <= sel_d;
      stat_q.ref_valid_now          <= ref_valid_d;
    end
  end

  // ==========================================================
  // Latched status, lock and interrupt pins
  // ==========================================================
  assign fault = {!stat_q.ref_valid_now, 1'b0, !stat_q.holdover_now_n,
                  !stat_q.synth_pll_locked_now_n,
                  !stat_q.vcxo_pll_locked_now_n,
                  ~stat_q.input_active_now};
  assign clr   = (wr_fire && avs_address_i == rshc_pkg::OFS_LATCHED &&
                  avs_byteenable_i[0]) ?
                 avs_writedata_i[rshc_pkg::ST_W-1:0] :
                 rshc_pkg::IE_RST;

  rshc_sticky #(
    .W (rshc_pkg::ST_W)
  ) u_sticky (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .fault_i   (fault),
    .clr_i     (clr),
    .lat_o     (lat_q)
  );

  assign irq_src = |(lat_q & ie_q);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_o       <= 1'b0;
      irq_out_n_o  <= 1'b1;
      vcxo_force_o <= 1'b1;
    end else begin
      lock_o       <= !lat_q[rshc_pkg::ST_VCXO] &&
                      !lat_q[rshc_pkg::ST_SYNTH];
      irq_out_n_o  <= !irq_src;
      vcxo_force_o <= ctrl_q[rshc_pkg::FORCE_BIT];
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_manual_hold_enter: assert property (manual_hold && st_q ==
    rshc_pkg::RSHC_NORMAL && req_sel != sel_q |=> st_q ==
    rshc_pkg::RSHC_HOLD && !stat_q.holdover_now_n && holdover_o
    && stat_q.selected_input_status == $past(req_sel))
    else $error("manual change did not enter holdover");
  a_manual_route_wait: assert property (manual_hold && hold_run &&
    !expire |=> $stable(route_q))
    else $error("manual route changed before expiry");
  a_auto_los_hold: assert property (auto_mode && st_q ==
    rshc_pkg::RSHC_NORMAL && los_evt |=> hold_run &&
    !stat_q.ref_valid_now && holdover_o)
    else $error("loss of signal did not start holdover");
  a_auto_sel_stable: assert property (auto_mode && hold_run &&
    !expire |=> $stable(route_q) && hold_run)
    else $error("selection moved during countdown");
  a_expire_keep: assert property (auto_mode && hold_run && expire &&
    clk_active_i[route_q] |=> !hold_run && $stable(route_q) ##1
    stat_q.ref_valid_now)
    else $error("valid active reference not kept");
  a_expire_switch: assert property (auto_mode && hold_run && expire &&
    !clk_active_i[route_q] && clk_active_i[!route_q] |=> !hold_run
    && route_q != $past(route_q))
    else $error("failover to other input missed");
  a_expire_none: assert property (auto_mode && hold_run && expire &&
    clk_active_i == 2'h0 |=> hold_run && $stable(route_q)
    && !stat_q.ref_valid_now)
    else $error("holdover left without a valid input");
  a_revert_off: assert property (auto_mode && !revert && !hold_run &&
    !los_evt |=> $stable(route_q))
    else $error("selection changed with revert disabled");
  a_prescale_idle: assert property (!hold_run |=>
    u_holdoff.pre_q == '0)
    else $error("prescaler ran outside hold-off");
  a_irq_mask: assert property (irq_src |=> !irq_out_n_o ##0
    $past(irq_src) == 1'b1)
    else $error("enabled latched bit did not reach interrupt");
  a_latch_holds: assert property (lat_q[0] && !clr[0] |=> lat_q[0])
    else $error("latched bit cleared without write");
  a_lock_pin: assert property (lat_q[rshc_pkg::ST_VCXO] |=> !lock_o)
    else $error("lock pin high with latched lock loss");
  a_force_copy: assert property (vcxo_force_o ==
    $past(ctrl_q[rshc_pkg::FORCE_BIT]))
    else $error("force pin does not follow control bit");

  c_manual_switch: cover property (manual_hold && hold_run ##1
    !hold_run);
  c_auto_failover: cover property (auto_mode && hold_run && expire &&
    !clk_active_i[route_q] && clk_active_i[!route_q]);
  c_revert: cover property (auto_mode && revert && !hold_run ##1
    $changed(route_q));
  c_irq: cover property ($fell(irq_out_n_o));

endmodule
